// ==== hw/erpc_regs.vh ====
// erpc_regs.vh: offsets, field positions, reset values and timing counts
// for the extended-resolution and pin-role register pair.
// assumes inclusion by bare name from the design files.
`ifndef ERPC_REGS_VH
`define ERPC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ERPC_OFF_LOW_BITS       8'h77
`define ERPC_OFF_PIN_ROLE       8'h78

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ERPC_RST_LOW_BITS       8'h00
`define ERPC_RST_PIN_ROLE       8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ERPC_LB_12V_LSB         0
`define ERPC_LB_REM1_LSB        2
`define ERPC_LB_LOCAL_LSB       4
`define ERPC_LB_REM2_LSB        6
`define ERPC_PR_ALERT_BIT       0
`define ERPC_PR_OVERTEMPERATURE_PIN_EN_BIT    1
`define ERPC_PR_BOOST_BIT       2

// ----------------------------------------------------------------
// shared pin function select codes
// ----------------------------------------------------------------
`define ERPC_SEL_FAN_FOUR_TACHOMETER          2'h0
`define ERPC_SEL_OVERTEMP       2'h1
`define ERPC_SEL_ALERT          2'h2
`define ERPC_SEL_GENERAL_IO_SIX          2'h3

// ----------------------------------------------------------------
// timing: timer tick of 22.76 ms expressed in ns at a 100 ns clock
// ----------------------------------------------------------------
`define ERPC_TICK_NS            22760000
`define ERPC_CLK_NS             100
`define ERPC_TICK_CYCLES        (`ERPC_TICK_NS / `ERPC_CLK_NS)

`endif

// ==== hw/erpc_ot_timer.v ====
// erpc_ot_timer.v: counts how long the overtemperature input stays asserted.
// assumes overtemp_i is synchronous to ref_clk_i and already qualified.
`timescale 1ns/10ps

module erpc_ot_timer #(
  parameter TICK_CYCLES = 227600,
  parameter CNT_W       = 18
) (
  // clock and reset
  input  wire             ref_clk_i,
  input  wire             rst_i,
  // overtemperature level
  input  wire             overtemp_i,
  // elapsed time in ticks, saturating
  output reg  [7:0]       ticks_o,
  output reg              active_o
);

  reg [CNT_W-1:0] div;

  // ----------------------------------------------------------------
  // tick divider and saturating count, restarted on each assertion
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      div      <= {CNT_W{1'b0}};
      ticks_o  <= 8'h00;
      active_o <= 1'b0;
    end else begin
      active_o <= overtemp_i;
      if (overtemp_i && !active_o) begin
        div     <= {CNT_W{1'b0}};
        ticks_o <= 8'h00;
      end else if (overtemp_i) begin
        if (div == TICK_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
          div <= {CNT_W{1'b0}};
          // saturate instead of wrapping so long events never read short
          if (ticks_o != 8'hff) begin
            ticks_o <= ticks_o + 8'h01;
          end
        end else begin
          div <= div + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // erpc_ot_timer

// ==== hw/erpc_top.v ====
// erpc_top.v: extended-resolution low-bit register with coherent-read freeze,
// and the pin-role / thermal configuration register with its pin steering.
// assumes a serial-bus front end that presents one-cycle read and write
// strobes with an 8-bit address; measurement engines supply 10-bit results
// with one-cycle valid pulses. all inputs are synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "erpc_regs.vh"

// Overview of operation
// - 12 V low bits in [1:0]
// - remote one low bits in [3:2]
// - on-chip temperature low bits in [5:4]
// - remote two low bits in [7:6]
// - reading low bits freezes matching result registers
// - bit 0 selects alert or fan two drive
// - bit 1 enables overtemperature pin function
// - overtemperature with auto mode runs fans full
// - timer measures overtemperature assertion length
// - thermal disabled makes pin 2.5 V input
// - direction bit makes overtemperature pin bidirectional on pin 22 only; pin 14 is never driven
// - select code maps shared pin role
// - lock bit makes configuration read-only
module erpc_top #(
  parameter TICK_CYCLES = `ERPC_TICK_CYCLES,
  parameter CNT_W       = 18
) (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rst_i,
  // register access from the serial front end
  input  wire        reg_rd_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  output reg  [7:0]  reg_rdata_o,
  // high-byte register reads (12 V, remote one, local, remote two)
  input  wire [3:0]  msb_rd_i,
  // conversion results
  input  wire [9:0]  v12_result_i,
  input  wire        v12_valid_i,
  input  wire [9:0]  rem1_result_i,
  input  wire        rem1_valid_i,
  input  wire [9:0]  local_result_i,
  input  wire        local_valid_i,
  input  wire [9:0]  rem2_result_i,
  input  wire        rem2_valid_i,
  // high bytes held for the high-byte registers
  output reg  [7:0]  v12_msb_o,
  output reg  [7:0]  rem1_msb_o,
  output reg  [7:0]  local_msb_o,
  output reg  [7:0]  rem2_msb_o,
  // shared configuration from other registers
  input  wire        config_lock_i,
  input  wire [1:0]  shared_pin_function_select_i,
  input  wire        overtemperature_pin_dir_i,
  input  wire        auto_fan_i,
  // pin side
  input  wire        overtemperature_pin_i,
  input  wire        fan_two_pwm_i,
  input  wire        alert_i,
  input  wire        overtemp_drive_i,
  output reg         pin10_alert_mode_o,
  output reg         pin10_out_o,
  output reg         pin22_overtemperature_pin_mode_o,
  output reg         pin22_out_o,
  output reg         pin22_oe_o,
  output reg         pin14_overtemperature_pin_mode_o,
  output reg  [1:0]  pin14_role_o,
  // fan control
  output reg         fans_full_o,
  output reg         fans_max_duty_o,
  output reg  [7:0]  ot_ticks_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [7:0] low_bits_voltage_temperature;
  reg  [7:0] pin_role_thermal_config;
  reg  [3:0] frozen;
  reg        ot_seen;
  wire [7:0] timer_ticks;
  wire       timer_active;
  wire       rd_low;
  wire       wr_cfg;
  wire       ot_active;
  wire       overtemperature_pin_en;
  wire       p14_overtemperature_pin;

  // decode the strobes once; a locked write is dropped silently, so the host
  // gets no indication and must read back to see whether it landed
  assign rd_low    = reg_rd_i && (reg_addr_i == `ERPC_OFF_LOW_BITS);
  assign wr_cfg    = reg_wr_i && (reg_addr_i == `ERPC_OFF_PIN_ROLE) && !config_lock_i;
  assign overtemperature_pin_en  = pin_role_thermal_config[`ERPC_PR_OVERTEMPERATURE_PIN_EN_BIT];
  assign p14_overtemperature_pin = (shared_pin_function_select_i == `ERPC_SEL_OVERTEMP);
  // active-low pin: low level means overtemperature
  assign ot_active = overtemperature_pin_en && !overtemperature_pin_i;

  // ----------------------------------------------------------------
  // slot update: a frozen slot ignores fresh results until released
  // ----------------------------------------------------------------
  function [7:0] erpc_slot;
    input [7:0] cur;
    input [9:0] res;
    input       take;
    begin
      erpc_slot = take ? res[9:2] : cur;
    end
  endfunction

  // ----------------------------------------------------------------
  // result capture and freeze
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_bits_voltage_temperature <= `ERPC_RST_LOW_BITS;
      v12_msb_o   <= 8'h00;
      rem1_msb_o  <= 8'h00;
      local_msb_o <= 8'h00;
      rem2_msb_o  <= 8'h00;
      frozen      <= 4'h0;
    end else begin
      // a read in the same cycle as a release keeps the freeze
      if (rd_low) begin
        frozen <= 4'hf;
      end else begin
        frozen <= frozen & ~msb_rd_i;
      end
      if (v12_valid_i && !frozen[0]) begin
        low_bits_voltage_temperature[`ERPC_LB_12V_LSB +: 2] <= v12_result_i[1:0];
      end
      if (rem1_valid_i && !frozen[1]) begin
        low_bits_voltage_temperature[`ERPC_LB_REM1_LSB +: 2] <= rem1_result_i[1:0];
      end
      if (local_valid_i && !frozen[2]) begin
        low_bits_voltage_temperature[`ERPC_LB_LOCAL_LSB +: 2] <= local_result_i[1:0];
      end
      if (rem2_valid_i && !frozen[3]) begin
        low_bits_voltage_temperature[`ERPC_LB_REM2_LSB +: 2] <= rem2_result_i[1:0];
      end
      v12_msb_o   <= erpc_slot(v12_msb_o, v12_result_i, v12_valid_i && !frozen[0]);
      rem1_msb_o  <= erpc_slot(rem1_msb_o, rem1_result_i, rem1_valid_i && !frozen[1]);
      local_msb_o <= erpc_slot(local_msb_o, local_result_i, local_valid_i && !frozen[2]);
      rem2_msb_o  <= erpc_slot(rem2_msb_o, rem2_result_i, rem2_valid_i && !frozen[3]);
    end
  end

  // ----------------------------------------------------------------
  // configuration register and read data
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_role_thermal_config <= `ERPC_RST_PIN_ROLE;
      reg_rdata_o             <= 8'h00;
    end else begin
      if (wr_cfg) begin
        pin_role_thermal_config <= reg_wdata_i;
      end
      // unmapped addresses read zero so a stray read never shows stale state
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ERPC_OFF_LOW_BITS: reg_rdata_o <= low_bits_voltage_temperature;
          `ERPC_OFF_PIN_ROLE: reg_rdata_o <= pin_role_thermal_config;
          default:            reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // overtemperature timer
  // ----------------------------------------------------------------
  erpc_ot_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .CNT_W       (CNT_W)
  ) u_timer (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .overtemp_i (ot_active),
    .ticks_o    (timer_ticks),
    .active_o   (timer_active)
  );

  // ----------------------------------------------------------------
  // pin steering and fan overrides
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin10_alert_mode_o <= 1'b0;
      pin10_out_o        <= 1'b0;
      pin22_overtemperature_pin_mode_o <= 1'b0;
      pin22_out_o        <= 1'b0;
      pin22_oe_o         <= 1'b0;
      pin14_overtemperature_pin_mode_o <= 1'b0;
      pin14_role_o       <= `ERPC_SEL_FAN_FOUR_TACHOMETER;
      fans_full_o        <= 1'b0;
      fans_max_duty_o    <= 1'b0;
      ot_ticks_o         <= 8'h00;
      ot_seen            <= 1'b0;
    end else begin
      pin10_alert_mode_o <= pin_role_thermal_config[`ERPC_PR_ALERT_BIT];
      pin10_out_o        <= pin_role_thermal_config[`ERPC_PR_ALERT_BIT] ?
                            alert_i : fan_two_pwm_i;
      // select 01 moves the function to the shared pin, leaving 2.5 V input here
      pin22_overtemperature_pin_mode_o <= overtemperature_pin_en && !p14_overtemperature_pin;
      pin14_overtemperature_pin_mode_o <= overtemperature_pin_en && p14_overtemperature_pin;
      pin14_role_o       <= shared_pin_function_select_i;
      // pin is driven low only when direction allows it; else timer input only
      pin22_out_o        <= 1'b0;
      pin22_oe_o         <= overtemperature_pin_en && !p14_overtemperature_pin && overtemperature_pin_dir_i && overtemp_drive_i;
      // the fan overrides follow the pin one cycle late; the fan loops must
      // treat them as levels, not as pulses
      fans_full_o        <= ot_active && auto_fan_i;
      fans_max_duty_o    <= ot_active && pin_role_thermal_config[`ERPC_PR_BOOST_BIT];
      ot_seen            <= timer_active;
      // the count shows once the timer has seen the assertion for a cycle
      ot_ticks_o         <= ot_seen ? timer_ticks : ot_ticks_o;
    end
  end

endmodule // erpc_top

// ==== verif/erpc_props.sv ====
// erpc_props.sv: port-level assertions for erpc_top.
// assumes it is bound onto erpc_top, one clock domain, outputs one cycle behind.
`timescale 1ns/10ps
module erpc_props (
  input wire logic       ref_clk_i, rst_i, reg_rd_i, alert_i, fan_two_pwm_i, auto_fan_i,
  input wire logic       overtemperature_pin_dir_i, overtemp_drive_i, pin10_alert_mode_o, pin10_out_o,
  input wire logic       pin14_overtemperature_pin_mode_o, pin22_overtemperature_pin_mode_o, fans_full_o, pin22_oe_o,
  input wire logic [1:0] shared_pin_function_select_i, pin14_role_o,
  input wire logic [3:0] msb_rd_i,
  input wire logic [7:0] reg_addr_i, v12_msb_o, ot_ticks_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // mode held two cycles, so either output latency lands on the same mux input
  property p_mux;
    !$past(rst_i) && $stable(pin10_alert_mode_o) |->
      pin10_out_o == $past(pin10_alert_mode_o ? alert_i : fan_two_pwm_i);
  endproperty
  a_mux: assert property (p_mux) else $error("pin10 mux wrong");
  property p_role;
    !$past(rst_i) |-> pin14_role_o == $past(shared_pin_function_select_i);
  endproperty
  a_role: assert property (p_role) else $error("pin14 role wrong");
  property p_t14;
    pin14_overtemperature_pin_mode_o |-> pin14_role_o == 2'h1;
  endproperty
  a_t14: assert property (p_t14) else $error("pin14 overtemperature_pin mode wrong");
  property p_t22;
    pin22_overtemperature_pin_mode_o |-> pin14_role_o != 2'h1;
  endproperty
  a_t22: assert property (p_t22) else $error("pin22 overtemperature_pin mode wrong");
  property p_full;
    fans_full_o |-> $past(auto_fan_i);
  endproperty
  a_full: assert property (p_full) else $error("full speed without auto");
  property p_oe;
    pin22_oe_o |-> $past(overtemperature_pin_dir_i && overtemp_drive_i);
  endproperty
  a_oe: assert property (p_oe) else $error("pin22 driven wrongly");
  property p_frz;
    reg_rd_i && reg_addr_i == 8'h77 ##1 !msb_rd_i[0] |=> $stable(v12_msb_o);
  endproperty
  a_frz: assert property (p_frz) else $error("frozen byte changed");
  logic v12_held;
  // mirrors the freeze of the 12 V slot: a low-bit read sets it, a high-byte
  // read releases it, and a read in the same cycle as a release wins
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      v12_held <= 1'b0;
    end else if (reg_rd_i && reg_addr_i == 8'h77) begin
      v12_held <= 1'b1;
    end else if (msb_rd_i[0]) begin
      v12_held <= 1'b0;
    end
  end
  property p_frz_hold;
    v12_held |=> $stable(v12_msb_o);
  endproperty
  a_frz_hold: assert property (p_frz_hold) else $error("held byte changed");
  property p_tick;
    ot_ticks_o != 8'h00 && $past(ot_ticks_o) != 8'h00 |->
      ot_ticks_o - $past(ot_ticks_o) <= 8'h01;
  endproperty
  a_tick: assert property (p_tick) else $error("timer jumped");
endmodule // erpc_props

bind erpc_top erpc_props i_erpc_props (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .reg_rd_i(reg_rd_i), .alert_i(alert_i), .fan_two_pwm_i(fan_two_pwm_i),
  .auto_fan_i(auto_fan_i), .overtemperature_pin_dir_i(overtemperature_pin_dir_i), .overtemp_drive_i(overtemp_drive_i),
  .pin10_alert_mode_o(pin10_alert_mode_o), .pin10_out_o(pin10_out_o),
  .pin14_overtemperature_pin_mode_o(pin14_overtemperature_pin_mode_o), .pin22_overtemperature_pin_mode_o(pin22_overtemperature_pin_mode_o),
  .fans_full_o(fans_full_o), .pin22_oe_o(pin22_oe_o), .pin14_role_o(pin14_role_o),
  .shared_pin_function_select_i(shared_pin_function_select_i), .msb_rd_i(msb_rd_i),
  .reg_addr_i(reg_addr_i), .v12_msb_o(v12_msb_o), .ot_ticks_o(ot_ticks_o));

// ==== verif/erpc_host_model.sv ====
// erpc_host_model.sv: bus host issuing single register reads and writes.
// assumes one-cycle strobes sampled on the shared rising clock edge.
`timescale 1ns/10ps
module erpc_host_model (
  input  wire logic       ref_clk_i,
  output logic            reg_rd_o, reg_wr_o,
  output logic      [7:0] reg_addr_o, reg_wdata_o
);
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  task automatic xfer(input logic w, input logic [7:0] a, dat);
    @(posedge ref_clk_i);
    reg_rd_o <= !w;
    reg_wr_o <= w;
    reg_addr_o <= a;
    reg_wdata_o <= dat;
    @(posedge ref_clk_i);
    // released lines flip so a stale address never passes as valid
    reg_rd_o <= 1'b0;
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~dat;
    @(posedge ref_clk_i);
    #1;
  endtask
endmodule // erpc_host_model

// ==== verif/tb_top.sv ====
// tb_top.sv: self-checking bench for erpc_top with a register host model.
// assumes a 10 MHz clock; the timer tick is shortened to 4 cycles.
`timescale 1ns/10ps
module tb_top;
  logic       clk = 0, rst = 1, lock = 0, dir = 0, auto = 0, otp = 1, pwm = 0;
  logic       alrt = 0, drv = 0, rd, wr, m10, o10, m22, o22, oe22, m14, full, maxd;
  logic [1:0] sel = 0, role;
  logic [3:0] msb_rd = 0, vld = 0;
  logic [7:0] addr, wdat, rdat, tick, msb [4];
  logic [9:0] res [4] = '{default: 10'h000};
  int         n_errors = 0, checks = 0;
  always #50 clk = ~clk;
  erpc_host_model i_erpc_host_model (.ref_clk_i(clk), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_addr_o(addr), .reg_wdata_o(wdat));
  erpc_top #(.TICK_CYCLES(4)) i_erpc_top (.ref_clk_i(clk), .rst_i(rst), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat),
    .msb_rd_i(msb_rd), .v12_result_i(res[0]), .v12_valid_i(vld[0]),
    .rem1_result_i(res[1]), .rem1_valid_i(vld[1]), .local_result_i(res[2]),
    .local_valid_i(vld[2]), .rem2_result_i(res[3]), .rem2_valid_i(vld[3]),
    .v12_msb_o(msb[0]), .rem1_msb_o(msb[1]), .local_msb_o(msb[2]), .rem2_msb_o(msb[3]),
    .config_lock_i(lock), .shared_pin_function_select_i(sel), .overtemperature_pin_dir_i(dir),
    .auto_fan_i(auto), .overtemperature_pin_i(otp), .fan_two_pwm_i(pwm), .alert_i(alrt),
    .overtemp_drive_i(drv), .pin10_alert_mode_o(m10), .pin10_out_o(o10),
    .pin22_overtemperature_pin_mode_o(m22), .pin22_out_o(o22), .pin22_oe_o(oe22),
    .pin14_overtemperature_pin_mode_o(m14), .pin14_role_o(role), .fans_full_o(full),
    .fans_max_duty_o(maxd), .ot_ticks_o(tick));
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, exp);
    i_erpc_host_model.xfer(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask
  task automatic rel(input logic [3:0] m);
    msb_rd <= m;
    cyc(1);
    msb_rd <= 4'h0;
    cyc(1);
  endtask
  task automatic send(input logic [9:0] a, b, c, e);
    res <= '{a, b, c, e};
    vld <= 4'hf;
    cyc(1);
    vld <= 4'h0;
    cyc(1);
  endtask
  task automatic t_lowbits;
    rd_chk(8'h77, 8'h00);
    rd_chk(8'h78, 8'h00);
    rd_chk(8'h5a, 8'h00);
    rel(4'hf);
    send(10'h2a5, 10'h13e, 10'h0c7, 10'h2f0);
    chk(msb[0], 8'ha9);
    i_erpc_host_model.xfer(1'b0, 8'h77, 8'h00);
    chk({6'h00, rdat[1:0]}, 8'h01);
    chk({6'h00, rdat[3:2]}, 8'h02);
    chk({6'h00, rdat[5:4]}, 8'h03);
    chk({6'h00, rdat[7:6]}, 8'h00);
    send(10'h000, 10'h000, 10'h000, 10'h000);
    chk(msb[3], 8'hbc);
    rd_chk(8'h77, 8'h39);
    rel(4'h1);
    send(10'h3ff, 10'h3ff, 10'h3ff, 10'h3ff);
    chk(msb[0], 8'hff);
    chk(msb[1], 8'h4f);
    rel(4'he);
  endtask
  task automatic t_cfg;
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h02);
    for (int i = 0; i < 4; i++) begin
      sel <= i[1:0];
      cyc(2);
      chk(role, i[1:0]);
      chk(m14, i == 1);
      chk(m22, i != 1);
    end
    sel <= 2'h0;
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h00);
    chk(m22, 1'b0);
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h07);
    lock <= 1'b1;
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h00);
    rd_chk(8'h78, 8'h07);
    lock <= 1'b0;
  endtask
  task automatic t_pins;
    alrt <= 1'b1;
    cyc(2);
    chk({m10, o10}, 2'b11);
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h06);
    cyc(1);
    chk({m10, o10}, 2'b00);
    drv <= 1'b1;
    dir <= 1'b1;
    cyc(2);
    chk({oe22, o22}, 2'b10);
    dir <= 1'b0;
    cyc(2);
    chk(oe22, 1'b0);
  endtask
  task automatic t_overtemperature_pin;
    auto <= 1'b1;
    otp <= 1'b0;
    cyc(20);
    chk({full, maxd}, 2'b11);
    chk(tick >= 8'h03 && tick <= 8'h05, 1'b1);
    otp <= 1'b1;
    i_erpc_host_model.xfer(1'b1, 8'h78, 8'h02);
    chk(full, 1'b0);
    otp <= 1'b0;
    cyc(3);
    chk({full, maxd}, 2'b10);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_lowbits;
    t_cfg;
    t_pins;
    t_overtemperature_pin;
    end_sim;
  end
endmodule // tb_top
